// File: hdl/drive_interlock.sv
// Position interlock, trigger gating and local drive for four axes
`timescale 1ns/1ps
`include "drive_interlock_defines.svh"
// Notes on behaviour
// - Feed power on applies translator power and retracts the stow pin.
// - A tripped limit blocks triggers for its own direction only.
// - Each tripped limit lights its console limit lamp while tripped.
// - Outer east/west pass-through switches light lamps outside middle range.
// - Carriage inside outer east limit removes focus translator power.
// - Focus below up-limit switch removes carriage feed power.
// - Focus in restrictive zone lights lamp, removes rotation and mount HA power.
// - Each zero switch lights its zero lamp at zero position.
// - In restrictive zone, upward focus blocked unless rotation at zero.
// - Motion only while permit actively asserted; lost permit stops motion.
// - Each negative trigger step moves motor one step that way.
// - Local button powers translator and runs internal adjustable step generator.
// - Local service drive bypasses every limit interlock.
// - Receiver cleans slow drive pulses into fast steps with hysteresis.
// - Brake release only with focus power on and motor current sufficient.
// - Focus power removal drops brake release at once.
module drive_interlock
  import drive_interlock_pkg::*;
#(
  parameter int DEB_CYC = `DEB_CYC
)
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  input  wire sw_s         SW_I,
  input  wire btn_s        BTN_I,
  input  wire logic [3:0]  TRIG_FWD_I,
  input  wire logic [3:0]  TRIG_REV_I,
  input  wire logic        CUR_OK_I,
  output logic      [3:0]  PWR_O,
  output logic             STOW_REL_O,
  output logic             BRAKE_REL_O,
  output logic      [3:0]  STEP_FWD_N_O,
  output logic      [3:0]  STEP_REV_N_O,
  output lamp_s            LAMP_O,
  output logic             IRQ_O
);

  localparam int NIN = $bits(sw_s) + $bits(btn_s);
  localparam int DW  = $clog2(DEB_CYC + 1);

  // Refuse a settling count below two cycles
  if (DEB_CYC < 2)
  begin : g_chk
    $error("DEB_CYC must be at least 2");
  end

  //**********************************************************
  // Switch conditioning
  //**********************************************************

  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] deb;
  sw_s            sw;
  btn_s           btn;

  assign raw_in = {SW_I, BTN_I};
  assign sw     = deb[NIN-1 -: $bits(sw_s)];
  assign btn    = deb[$bits(btn_s)-1:0];

  // Two-flop sync, then accept a level only after it holds
  for (genvar i = 0; i < NIN; i++)
  begin : g_deb
    logic          s1;
    logic          s2;
    logic [DW-1:0] cnt;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        s1 <= 1'b0;
        s2 <= 1'b0;
      end
      else
      begin
        s1 <= raw_in[i];
        s2 <= s1;
      end
    end
    // Zero after reset means unsafe, so permits start withdrawn
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        cnt    <= '0;
        deb[i] <= 1'b0;
      end
      else if (s2 == deb[i])
        cnt <= '0;
      else if (cnt == DW'(DEB_CYC - 1))
      begin
        cnt    <= '0;
        deb[i] <= s2;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

  //**********************************************************
  // Trigger pulse receivers
  //**********************************************************

  logic [7:0] trig_raw;
  logic [7:0] trig;

  assign trig_raw = {TRIG_REV_I, TRIG_FWD_I};

  // Integrator with two thresholds rejects slow edges and noise
  for (genvar i = 0; i < 8; i++)
  begin : g_rx
    logic             t1;
    logic             t2;
    logic [`HYS_W-1:0] acc;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        t1 <= 1'b0;
        t2 <= 1'b0;
      end
      else
      begin
        t1 <= trig_raw[i];
        t2 <= t1;
      end
    end
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        acc <= '0;
      else if (t2 && acc != `HYS_MAX)
        acc <= acc + 1'b1;
      else if (!t2 && acc != '0)
        acc <= acc - 1'b1;
    end
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        trig[i] <= 1'b0;
      else if (acc >= `HYS_HI)
        trig[i] <= 1'b1;
      else if (acc <= `HYS_LO)
        trig[i] <= 1'b0;
    end
  end

  //**********************************************************
  // Register file
  //**********************************************************

  logic [3:0]         en;
  logic [`NEV-1:0]    irq_st;
  logic [`NEV-1:0]    irq_mask;
  logic [`RATE_W-1:0] rate;
  logic [`NEV-1:0]    ev;
  logic [31:0]        next_rdata;
  logic [3:0]         loc;

  // Software power requests and settings
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      en       <= `CTRL_RST;
      irq_mask <= `IMSK_RST;
      rate     <= `RATE_RST;
    end
    else if (WR_I)
    begin
      if (ADDR_I == `A_CTRL)
        en <= WDATA_I[3:0];
      if (ADDR_I == `A_IMSK)
        irq_mask <= WDATA_I[`NEV-1:0];
      if (ADDR_I == `A_RATE)
        rate <= WDATA_I[`RATE_W-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_st <= '0;
    else if (WR_I && ADDR_I == `A_IRQS)
      irq_st <= (irq_st & ~WDATA_I[`NEV-1:0]) | ev;
    else
      irq_st <= irq_st | ev;
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    next_rdata = '0;
    if (RD_I)
    begin
      unique case (ADDR_I)
        `A_CTRL: next_rdata[3:0] = en;
        `A_STAT:
        begin
          next_rdata[3:0]          = PWR_O;
          next_rdata[`ST_BRK]      = BRAKE_REL_O;
          next_rdata[`ST_STOW]     = STOW_REL_O;
          next_rdata[`ST_LOC +: 4] = loc;
          next_rdata[`ST_LAMP +: $bits(lamp_s)] = LAMP_O;
        end
        `A_IRQS: next_rdata[`NEV-1:0]    = irq_st;
        `A_IMSK: next_rdata[`NEV-1:0]    = irq_mask;
        `A_RATE: next_rdata[`RATE_W-1:0] = rate;
        default: next_rdata = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      RDATA_O <= '0;
    else
      RDATA_O <= next_rdata;
  end

  //**********************************************************
  // Interlock permits and power
  //**********************************************************

  logic [3:0] permit;
  logic [3:0] remote_on;
  logic [3:0] next_pwr;
  logic       cur1;
  logic       cur2;
  logic       loc_any_q;
  logic [7:0] lim_q;

  assign loc = btn.fwd | btn.rev;

  // Each permit is a high level; a broken line withdraws it
  always_comb
  begin
    permit          = '0;
    permit[`AX_FEED] = sw.up_reached;
    permit[`AX_MHA]  = sw.rfd_below;
    permit[`AX_ROT]  = sw.rfd_below;
    permit[`AX_FOC]  = sw.e1_out;
  end

  // Local buttons override interlocks for service work
  assign remote_on = en & permit;
  assign next_pwr  = remote_on | loc;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PWR_O      <= '0;
      STOW_REL_O <= 1'b0;
    end
    else
    begin
      PWR_O      <= next_pwr;
      STOW_REL_O <= next_pwr[`AX_FEED];
    end
  end

  // Current sense is a plain level, synchronised only
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cur1 <= 1'b0;
      cur2 <= 1'b0;
    end
    else
    begin
      cur1 <= CUR_OK_I;
      cur2 <= cur1;
    end
  end

  // Brake follows next power so it drops on the same edge
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      BRAKE_REL_O <= 1'b0;
    else
      BRAKE_REL_O <= next_pwr[`AX_FOC] & cur2;
  end

  //**********************************************************
  // Step trigger gating
  //**********************************************************

  logic [3:0]         fwd_ok;
  logic [3:0]         rev_ok;
  logic [`RATE_W-1:0] gen_cnt;
  logic               gen_lvl;

  // Direction permits from limits; upward focus has an extra guard
  always_comb
  begin
    for (int a = 0; a < `NAX; a++)
    begin
      fwd_ok[a] = remote_on[a] & sw.lim_ok[2*a];
      rev_ok[a] = remote_on[a] & sw.lim_ok[2*a+1];
    end
    fwd_ok[`AX_FOC] = fwd_ok[`AX_FOC]
                      & (sw.rfd_below | sw.zero[`AX_ROT]);
  end

  // Shared service generator; a zero rate toggles every cycle
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      gen_cnt <= '0;
      gen_lvl <= 1'b0;
    end
    else if (gen_cnt >= rate)
    begin
      gen_cnt <= '0;
      gen_lvl <= ~gen_lvl;
    end
    else
      gen_cnt <= gen_cnt + 1'b1;
  end

  // Each falling output edge is one motor step
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      STEP_FWD_N_O <= '1;
      STEP_REV_N_O <= '1;
    end
    else
    begin
      for (int a = 0; a < `NAX; a++)
      begin
        if (loc[a])
        begin
          STEP_FWD_N_O[a] <= ~(gen_lvl & btn.fwd[a]);
          STEP_REV_N_O[a] <= ~(gen_lvl & btn.rev[a]);
        end
        else
        begin
          STEP_FWD_N_O[a] <= ~(trig[a] & fwd_ok[a]);
          STEP_REV_N_O[a] <= ~(trig[a+4] & rev_ok[a]);
        end
      end
    end
  end

  //**********************************************************
  // Console lamps and interrupt
  //**********************************************************

  // Lamps track debounced switch levels
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      LAMP_O <= '0;
    else
    begin
      LAMP_O.lim  <= ~sw.lim_ok;
      LAMP_O.e1   <= sw.e1_out;
      LAMP_O.w1   <= sw.w1_out;
      LAMP_O.restrictive_focus_zone  <= ~sw.rfd_below;
      LAMP_O.zero <= sw.zero;
    end
  end

  // Edge history for events; starts like the debounced levels, so no false trip
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lim_q     <= '0;
      loc_any_q <= 1'b0;
    end
    else
    begin
      lim_q     <= sw.lim_ok;
      loc_any_q <= |loc;
    end
  end

  // Limit trip, interlock power loss, service drive entry
  always_comb
  begin
    ev          = '0;
    ev[`EV_LIM] = |(lim_q & ~sw.lim_ok);
    ev[`EV_PWR] = |(en & PWR_O & ~next_pwr);
    ev[`EV_LOC] = (|loc) & ~loc_any_q;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_st & irq_mask);
  end

  //**********************************************************
  // Assertions
  //**********************************************************

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_foc_up_blocked;
    !sw.rfd_below && !sw.zero[`AX_ROT] && !loc[`AX_FOC];
  endsequence

  sequence s_feed_held;
    !sw.up_reached && !loc[`AX_FEED];
  endsequence

  a_stow_tracks_pwr: assert property (STOW_REL_O == PWR_O[`AX_FEED])
    else $error("stow pin release differs from feed power");

  a_limit_blocks_fwd: assert property (
    !sw.lim_ok[6] && !loc[`AX_FOC] |=> STEP_FWD_N_O[`AX_FOC])
    else $error("focus up step passed a tripped limit");

  a_limit_lamp_on: assert property (
    !sw.lim_ok[1] [*2] |-> LAMP_O.lim[1])
    else $error("limit lamp dark while switch tripped");

  a_focus_pwr_cut: assert property (
    !sw.e1_out && !loc[`AX_FOC] |=> !PWR_O[`AX_FOC])
    else $error("focus powered with carriage inside east limit");

  a_feed_pwr_cut: assert property (s_feed_held |=> !PWR_O[`AX_FEED])
    else $error("feed powered with focus below up limit");

  a_rfd_pwr_cut: assert property (
    !sw.rfd_below && !loc[`AX_ROT] |=> !PWR_O[`AX_ROT] && LAMP_O.restrictive_focus_zone)
    else $error("rotation powered in restrictive zone");

  a_up_focus_held: assert property (s_foc_up_blocked |=> STEP_FWD_N_O[`AX_FOC])
    else $error("upward focus step in restrictive zone");

  a_brake_needs_pwr: assert property (BRAKE_REL_O |-> PWR_O[`AX_FOC])
    else $error("brake released without focus power");

  a_brake_drops: assert property ($fell(PWR_O[`AX_FOC]) |-> !BRAKE_REL_O)
    else $error("brake release outlived focus power");

  a_local_bypass: assert property (
    btn.fwd[`AX_MHA] && !sw.lim_ok[2] |=> PWR_O[`AX_MHA] ##1 1'b1)
    else $error("service drive not powered past limit");

endmodule

// File: hdl/drive_interlock_defines.svh
// Constants for the telescope drive interlock block
`ifndef DRIVE_INTERLOCK_DEFINES_SVH
`define DRIVE_INTERLOCK_DEFINES_SVH

// Clock rate and switch settling time
`define CLK_MHZ    10
`define DEB_US     1000
`define DEB_CYC    (`DEB_US * `CLK_MHZ)

// Trigger receiver integrator thresholds
`define HYS_W      4
`define HYS_MAX    4'hF
`define HYS_HI     4'hC
`define HYS_LO     4'h3

// Axis indices
`define AX_FEED    0
`define AX_MHA     1
`define AX_ROT     2
`define AX_FOC     3
`define NAX        4

// Register byte addresses
`define A_CTRL     8'h00
`define A_STAT     8'h04
`define A_IRQS     8'h08
`define A_IMSK     8'h0C
`define A_RATE     8'h10

// Reset values
`define CTRL_RST   4'h0
`define IMSK_RST   3'h0
`define RATE_W     24
`define RATE_RST   24'h00C350

// Interrupt event bits
`define NEV        3
`define EV_LIM     0
`define EV_PWR     1
`define EV_LOC     2

// Status register field positions
`define ST_BRK     4
`define ST_STOW    5
`define ST_LOC     8
`define ST_LAMP    12

`endif

// File: hdl/drive_interlock_pkg.sv
// Types shared by the telescope drive interlock block
package drive_interlock_pkg;

  // Switch levels; high means the safe or permitting condition
  typedef struct packed {
    logic [7:0] lim_ok;     // Per axis: [2a] forward, [2a+1] reverse
    logic       e1_out;     // Carriage outside middle range, east
    logic       w1_out;     // Carriage outside middle range, west
    logic       up_reached; // Focus at adjustable up limit
    logic       rfd_below;  // Focus below restrictive_focus_zone
    logic [3:0] zero;       // Axis zero switches
  } sw_s;

  // Local service push-buttons
  typedef struct packed {
    logic [3:0] fwd;
    logic [3:0] rev;
  } btn_s;

  // Console indicator lights
  typedef struct packed {
    logic [7:0] lim;
    logic       e1;
    logic       w1;
    logic       restrictive_focus_zone;
    logic [3:0] zero;
  } lamp_s;

endpackage

// File: tb/drive_far_side.sv
// Model of the remote pulse source and the four step translators
`timescale 1ns/1ps
module drive_far_side
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            go_i,
  input  wire logic            rev_i,
  input  wire logic [1:0]      axis_i,
  input  wire logic [3:0]      num_i,
  input  wire logic [3:0]      step_fwd_n_i,
  input  wire logic [3:0]      step_rev_n_i,
  output logic      [3:0]      trig_fwd_o,
  output logic      [3:0]      trig_rev_o,
  output logic                 busy_o,
  output logic      [3:0][7:0] pos_o
);
  logic [3:0] left;
  logic [6:0] tmr;
  logic       hi;
  logic       dir;
  logic [1:0] ax;
  logic [3:0] fwd_d;
  logic [3:0] rev_d;

  // ************************************
  // Pulse source
  // ************************************
  // Long first and last gaps stand for the start and stop ramps
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      left <= 4'h0;
      tmr <= 7'h00;
      hi <= 1'b0;
      dir <= 1'b0;
      ax <= 2'h0;
      busy_o <= 1'b0;
    end
    else if (go_i)
    begin
      left <= num_i;
      dir <= rev_i;
      ax <= axis_i;
      tmr <= 7'h28;
      hi <= 1'b0;
      busy_o <= 1'b1;
    end
    else if (busy_o)
    begin
      if (tmr != 7'h00)
        tmr <= tmr - 7'h01;
      else if (hi)
      begin
        hi <= 1'b0;
        left <= left - 4'h1;
        tmr <= (left == 4'h2) ? 7'h28 : 7'h14;
        busy_o <= (left != 4'h1);
      end
      else
      begin
        hi <= 1'b1;
        tmr <= 7'h14;
      end
    end
  end

  // Slow, wide pulses; the receiver must clean them up
  assign trig_fwd_o = (hi && !dir) ? (4'h1 << ax) : 4'h0;
  assign trig_rev_o = (hi && dir) ? (4'h1 << ax) : 4'h0;

  // ************************************
  // Translators
  // ************************************
  // One falling trigger edge moves one step that way
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fwd_d <= 4'hF;
      rev_d <= 4'hF;
      pos_o <= '0;
    end
    else
    begin
      fwd_d <= step_fwd_n_i;
      rev_d <= step_rev_n_i;
      for (int a = 0; a < 4; a++)
        if (fwd_d[a] && !step_fwd_n_i[a])
          pos_o[a] <= pos_o[a] + 8'h01;
        else if (rev_d[a] && !step_rev_n_i[a])
          pos_o[a] <= pos_o[a] - 8'h01;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the drive interlock block
`timescale 1ns/1ps
module tb_top;
  import drive_interlock_pkg::*;
  localparam int DEB = 4;
  logic             clk;
  logic             rst_n;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic             rd_d;
  logic [31:0]      rdata;
  sw_s              sw;
  btn_s             btn;
  logic [3:0]       tf;
  logic [3:0]       tr;
  logic             cur_ok;
  logic [3:0]       pwr;
  logic             stow;
  logic             brk;
  logic [3:0]       sfn;
  logic [3:0]       srn;
  lamp_s            lamp;
  logic             irq;
  logic             go;
  logic             rev;
  logic [1:0]       axis;
  logic [3:0]       num;
  logic             busy;
  logic [3:0][7:0]  pos;
  logic [7:0]       p0;
  logic [31:0]      exp_q[$];
  string            nm_q[$];
  int               seed;
  int               mismatches;
  int               check_count;
  int               cycles;

  drive_interlock #(.DEB_CYC(DEB)) dut_u (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SW_I(sw), .BTN_I(btn),
    .TRIG_FWD_I(tf), .TRIG_REV_I(tr), .CUR_OK_I(cur_ok), .PWR_O(pwr), .STOW_REL_O(stow),
    .BRAKE_REL_O(brk), .STEP_FWD_N_O(sfn), .STEP_REV_N_O(srn), .LAMP_O(lamp), .IRQ_O(irq));

  drive_far_side far_u (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .rev_i(rev), .axis_i(axis),
    .num_i(num), .step_fwd_n_i(sfn), .step_rev_n_i(srn), .trig_fwd_o(tf), .trig_rev_o(tr),
    .busy_o(busy), .pos_o(pos));

  // ************************************
  // Clock, timeout and read monitor
  // ************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
    cycles++;
    if (rd_d)
      chk(nm_q.pop_front(), rdata, exp_q.pop_front());
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // Long enough for sync plus debounce to land
  task automatic settle();
    cyc(DEB + 12);
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    nm_q.push_back(n);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Remote burst, bounded wait, then time for the last step to land
  task automatic burst(logic [1:0] a, logic r, logic [3:0] n);
    @(posedge clk);
    go <= 1'b1;
    axis <= a;
    rev <= r;
    num <= n;
    @(posedge clk);
    go <= 1'b0;
    // Busy only shows one edge after go was taken
    @(posedge clk);
    for (int i = 0; i < 2000 && busy === 1'b1; i++)
      @(posedge clk);
    chk("burst done", 32'(busy), 32'h0);
    cyc(40);
  endtask

  function automatic lamp_s exp_lamp();
    return {~sw.lim_ok, sw.e1_out, sw.w1_out, ~sw.rfd_below, sw.zero};
  endfunction

  function automatic logic [31:0] stat(logic [3:0] p, logic [3:0] loc);
    return {5'h00, exp_lamp(), loc, 2'b00, p[0], 1'b0, p};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial
  begin
    seed = 32'h139C;
    {rst_n, addr, wdata, wr, rd, cur_ok, go, rev, axis, num} = '0;
    sw = '0;
    btn = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk("PWR_O", 32'(pwr), 32'h0);
    chk("STEP_N", 32'({sfn, srn}), 32'hFF);
    rd_reg(8'h00, 32'h0, "CTRL");
    rd_reg(8'h0C, 32'h0, "IMSK");
    rd_reg(8'h10, 32'h0000C350, "RATE");
    wr_reg(8'h14, 32'hFFFFFFFF);
    rd_reg(8'h14, 32'h0, "unmapped");
    $display("test reset done");
    sw <= '{lim_ok: 8'hFF, e1_out: 1'b1, w1_out: 1'b0, up_reached: 1'b1, rfd_below: 1'b1,
            zero: 4'($random(seed))};
    settle();
    wr_reg(8'h00, 32'hF);
    wr_reg(8'h08, 32'h7);
    wr_reg(8'h0C, 32'h7);
    cyc(4);
    chk("PWR_O", 32'(pwr), 32'hF);
    chk("STOW", 32'(stow), 32'h1);
    chk("LAMP", 32'(lamp), 32'(exp_lamp()));
    chk("IRQ", 32'(irq), 32'h0);
    rd_reg(8'h04, stat(4'hF, 4'h0), "STATUS");
    cur_ok <= 1'b1;
    cyc(5);
    chk("BRAKE", 32'(brk), 32'h1);
    cur_ok <= 1'b0;
    cyc(5);
    chk("BRAKE", 32'(brk), 32'h0);
    cur_ok <= 1'b1;
    cyc(5);
    wr_reg(8'h00, 32'h7);
    repeat (4)
    begin
      @(posedge clk);
      chk("BRAKE vs power", 32'(brk), 32'(pwr[3]));
    end
    chk("BRAKE", 32'(brk), 32'h0);
    wr_reg(8'h00, 32'hF);
    cur_ok <= 1'b0;
    $display("test power and brake done");
    burst(2'd0, 1'b0, 4'd3);
    chk("POS0", 32'(pos[0]), 32'h3);
    burst(2'd0, 1'b1, 4'd2);
    chk("POS0", 32'(pos[0]), 32'h1);
    $display("test triggers done");
    sw.lim_ok[0] <= 1'b0;
    settle();
    chk("LAMP", 32'(lamp), 32'(exp_lamp()));
    chk("IRQ", 32'(irq), 32'h1);
    rd_reg(8'h08, 32'h1, "IRQS");
    burst(2'd0, 1'b0, 4'd2);
    chk("POS0", 32'(pos[0]), 32'h1);
    burst(2'd0, 1'b1, 4'd1);
    chk("POS0", 32'(pos[0]), 32'h0);
    wr_reg(8'h0C, 32'h6);
    cyc(2);
    chk("IRQ masked", 32'(irq), 32'h0);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h0C, 32'h7);
    cyc(2);
    chk("IRQ cleared", 32'(irq), 32'h0);
    sw.lim_ok[1:0] <= 2'b01;
    cyc(2);
    sw.lim_ok[1] <= 1'b1;
    settle();
    chk("LAMP glitch", 32'(lamp), 32'(exp_lamp()));
    rd_reg(8'h08, 32'h0, "IRQS");
    $display("test limits done");
    sw.e1_out <= 1'b0;
    settle();
    chk("PWR_O", 32'(pwr), 32'h7);
    chk("LAMP", 32'(lamp), 32'(exp_lamp()));
    rd_reg(8'h08, 32'h2, "IRQS");
    sw.e1_out <= 1'b1;
    sw.w1_out <= 1'b1;
    settle();
    chk("PWR_O", 32'(pwr), 32'hF);
    chk("LAMP", 32'(lamp), 32'(exp_lamp()));
    sw.up_reached <= 1'b0;
    settle();
    chk("PWR_O", 32'(pwr), 32'hE);
    chk("STOW", 32'(stow), 32'h0);
    sw.up_reached <= 1'b1;
    sw.rfd_below <= 1'b0;
    sw.zero[2] <= 1'b0;
    settle();
    chk("PWR_O", 32'(pwr), 32'h9);
    chk("LAMP", 32'(lamp), 32'(exp_lamp()));
    burst(2'd3, 1'b0, 4'd2);
    chk("POS3 up", 32'(pos[3]), 32'h0);
    burst(2'd3, 1'b1, 4'd1);
    chk("POS3 down", 32'(pos[3]), 32'hFF);
    sw.zero[2] <= 1'b1;
    settle();
    burst(2'd3, 1'b0, 4'd2);
    chk("POS3 up", 32'(pos[3]), 32'h1);
    sw.rfd_below <= 1'b1;
    $display("test zones done");
    wr_reg(8'h10, 32'($random(seed)) & 32'h3);
    wr_reg(8'h00, 32'h0);
    sw.lim_ok[2] <= 1'b0;
    settle();
    wr_reg(8'h08, 32'h7);
    p0 = pos[1];
    btn.fwd[1] <= 1'b1;
    settle();
    chk("PWR_O", 32'(pwr), 32'h2);
    rd_reg(8'h04, stat(4'h2, 4'h2), "STATUS");
    rd_reg(8'h08, 32'h4, "IRQS");
    cyc(100);
    btn.fwd[1] <= 1'b0;
    settle();
    chk("local steps", 32'((pos[1] - p0) >= 8'd5), 32'h1);
    chk("PWR_O", 32'(pwr), 32'h0);
    $display("test local drive done");
    cyc(5);
    print_verdict();
  end
endmodule
